// *** hw/tbis_interleave_ctrl.sv ***
// Two-bank interleave strobe generation and same-bank wait-state insertion
`timescale 1ns/100ps
module tbis_interleave_ctrl
(
	input  wire logic                        I_CLK_SYS,    // Processor bus clock
	input  wire logic                        I_RST,        // Async reset, active high
	input  wire logic [tbis_pkg::ADDR_W-1:0] I_ADDR,       // Early pipelined address
	input  wire logic                        I_CMD_FIRST,  // Pulse: first command state begins
	input  wire logic                        I_CMD_ACTIVE, // Level: command active
	output logic [1:0]                       O_STROBE,     // Bank strobes, low = latched
	output tbis_pkg::tbis_bank_bus_t         O_BANK0,      // Bank 0 address and enables
	output tbis_pkg::tbis_bank_bus_t         O_BANK1,      // Bank 1 address and enables
	output logic                             O_WAIT        // Extra wait state in progress
);
	tbis_pkg::tbis_strobe_state_t state_ff [2];
	tbis_pkg::tbis_strobe_state_t nxt_state [2];
	tbis_pkg::tbis_bank_bus_t     early_bus;
	tbis_pkg::tbis_bank_bus_t     bank_bus [2];
	logic [1:0]                   strobe_ff;
	logic                         cmd_active_ff;
	logic                         cmd_end;
	logic                         bank_choice_decode;
	logic                         addr_bank;
	logic                         last_bank_ff;
	logic                         last_valid_ff;
	logic                         same_bank;
	logic [1:0]                   wait_cnt_ff;
	logic                         wait_ff;

	function automatic logic [tbis_pkg::CE_W-1:0] ce_decode(input logic [tbis_pkg::CE_SEL_W-1:0] sel);
		logic [tbis_pkg::CE_W-1:0] one_hot;
		one_hot = '0;
		one_hot[sel] = 1'b1;
		return one_hot;
	endfunction

	// Region hit enables strobes; chip enables come from upper address bits
	assign bank_choice_decode = (I_ADDR[tbis_pkg::REGION_LSB +: tbis_pkg::REGION_W]
		== tbis_pkg::MEM_REGION); // see R3
	assign addr_bank = I_ADDR[tbis_pkg::BANK_BIT]; // see R1
	always_comb
	begin
		early_bus.addr = I_ADDR;
		early_bus.ce   = bank_choice_decode ? ce_decode(I_ADDR[tbis_pkg::CE_LSB +: tbis_pkg::CE_SEL_W])
			: '0; // see R3
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			cmd_active_ff <= 1'b0;
		else
			cmd_active_ff <= I_CMD_ACTIVE;
	end

	assign cmd_end = cmd_active_ff && !I_CMD_ACTIVE;

	genvar b;
	generate
		for (b = 0; b < 2; b++)
		begin : g_bank
			always_comb
			begin
				nxt_state[b] = state_ff[b];
				unique case (state_ff[b])
					tbis_pkg::TBIS_BANK_IDLE:
					begin
						// Only the addressed, decoded bank drops; the other stays open
						if (I_CMD_FIRST && bank_choice_decode && (addr_bank == 1'(b)))
							nxt_state[b] = tbis_pkg::TBIS_BANK_HELD; // see R6, R7
					end
					tbis_pkg::TBIS_BANK_HELD:
					begin
						if (cmd_end)
							nxt_state[b] = tbis_pkg::TBIS_BANK_IDLE; // see R10
					end
					default:
						nxt_state[b] = tbis_pkg::TBIS_BANK_IDLE;
				endcase
			end

			always_ff @(posedge I_CLK_SYS or posedge I_RST)
			begin
				if (I_RST)
					state_ff[b] <= tbis_pkg::TBIS_BANK_IDLE;
				else
					state_ff[b] <= nxt_state[b];
			end

			always_ff @(posedge I_CLK_SYS or posedge I_RST)
			begin
				if (I_RST)
					strobe_ff[b] <= tbis_pkg::STROBE_RESET[b]; // see R4
				else
					strobe_ff[b] <= (nxt_state[b] == tbis_pkg::TBIS_BANK_IDLE); // see R4, R6
			end

			// Latch samples on the same edge the strobe falls, so it captures this address
			tbis_bank_latch u_latch
			(
				.i_clk    (I_CLK_SYS),
				.i_rst    (I_RST),
				.i_strobe (strobe_ff[b]),
				.i_bus    (early_bus),
				.o_bus    (bank_bus[b])
			); // see R2, R5
		end
	endgenerate

	// Last-access record; invalid after reset so the first access never waits
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			last_bank_ff  <= 1'b0;
			last_valid_ff <= 1'b0; // see R12
		end
		else if (I_CMD_FIRST && bank_choice_decode)
		begin
			last_bank_ff  <= addr_bank; // see R12
			last_valid_ff <= 1'b1;
		end
	end

	assign same_bank = I_CMD_FIRST && bank_choice_decode && last_valid_ff
		&& (last_bank_ff == addr_bank); // see R8

	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			wait_cnt_ff <= tbis_pkg::WAIT_CNT_ZERO;
		else if (same_bank)
			wait_cnt_ff <= 2'(tbis_pkg::WAIT_CLKS); // see R9, R11
		else if (wait_cnt_ff != tbis_pkg::WAIT_CNT_ZERO)
			wait_cnt_ff <= wait_cnt_ff - 2'h1;
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			wait_ff <= 1'b0;
		else
			wait_ff <= same_bank || (wait_cnt_ff > 2'h1); // see R9, R11
	end

	assign O_STROBE = strobe_ff;
	assign O_BANK0  = bank_bus[0];
	assign O_BANK1  = bank_bus[1];
	assign O_WAIT   = wait_ff;
endmodule

// *** hw/tbis_pkg.sv ***
// Constants and carrier types for the two-bank interleave strobe control
// Notes on behaviour
// R1 - Two banks; consecutive words alternate banks, address bit 1 picks the bank.
// R2 - Each bank has its own address latch and its own address strobe.
// R3 - Decoder makes chip enables; decoded bank choice gates which strobe may drop.
// R4 - Both strobes rest high; each stays high until its bank is accessed.
// R5 - High strobe keeps its latch transparent to the early processor address.
// R6 - Addressed bank strobe drops at first command state, capturing address and selects.
// R7 - Strobe of the bank not addressed stays high during the access.
// R8 - Detect two consecutive accesses to the same bank.
// R9 - Same-bank back-to-back access inserts one extra wait state.
// R10 - Low strobe returns high once the preceding command goes inactive.
// R11 - One wait state stretches the bus cycle by two processor clocks.
// R12 - Last-bank record kept per access, cleared by reset; first access has no wait.
package tbis_pkg;
	localparam int unsigned ADDR_W        = 24;
	localparam int unsigned BANK_BIT      = 1;
	localparam int unsigned CE_W          = 8;
	localparam int unsigned CE_LSB        = 17;
	localparam int unsigned CE_SEL_W      = 3;
	localparam int unsigned REGION_LSB    = 20;
	localparam int unsigned REGION_W      = 4;
	localparam logic [3:0]  MEM_REGION    = 4'h0;
	localparam int unsigned WAIT_CLKS     = 2;
	localparam logic [1:0]  STROBE_RESET  = 2'h3;
	localparam logic [1:0]  WAIT_CNT_ZERO = 2'h0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [CE_W-1:0]   ce;
	} tbis_bank_bus_t;

	typedef enum logic [1:0] {
		TBIS_BANK_IDLE = 2'b01,
		TBIS_BANK_HELD = 2'b10
	} tbis_strobe_state_t;
endpackage

// *** hw/tbis_bank_latch.sv ***
// Per-bank address and chip-select latch, transparent while its strobe is high
`timescale 1ns/100ps
module tbis_bank_latch
(
	input  wire logic                    i_clk,    // System clock
	input  wire logic                    i_rst,    // Async reset, active high
	input  wire logic                    i_strobe, // Bank strobe, high = transparent
	input  wire tbis_pkg::tbis_bank_bus_t i_bus,   // Early address and selects
	output tbis_pkg::tbis_bank_bus_t      o_bus    // Latched address and selects
);
	tbis_pkg::tbis_bank_bus_t bus_ff;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			bus_ff <= '0;
		else if (i_strobe)
			bus_ff <= i_bus; // see R5
	end

	assign o_bus = bus_ff;
endmodule

// *** bench/tbis_interleave_monitor.sv ***
// Assertion checker for the interleave strobe control
`timescale 1ns/100ps
module tbis_interleave_monitor
(
	input wire logic                        I_CLK_SYS,    // Processor bus clock
	input wire logic                        I_RST,        // Async reset, active high
	input wire logic [tbis_pkg::ADDR_W-1:0] I_ADDR,       // Early pipelined address
	input wire logic                        I_CMD_FIRST,  // First command state pulse
	input wire logic                        I_CMD_ACTIVE, // Command active level
	input wire logic [1:0]                  O_STROBE,     // Bank strobes
	input wire tbis_pkg::tbis_bank_bus_t    O_BANK0,      // Bank 0 latch output
	input wire tbis_pkg::tbis_bank_bus_t    O_BANK1,      // Bank 1 latch output
	input wire logic                        O_WAIT        // Extra wait state
);
	logic hit;
	logic last_ff;
	logic have_ff;
	assign hit = I_CMD_FIRST && I_ADDR[23:20] == tbis_pkg::MEM_REGION;
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			have_ff <= 1'h0;
		else if (hit)
			have_ff <= 1'h1;
	end
	always_ff @(posedge I_CLK_SYS)
	begin
		if (hit)
			last_ff <= I_ADDR[1];
	end
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	sequence take0; hit && !I_ADDR[1] && &O_STROBE; endsequence
	sequence take1; hit && I_ADDR[1] && &O_STROBE; endsequence
	sequence same; hit && have_ff && I_ADDR[1] == last_ff; endsequence
	a_bank0_strobe_drop: assert property (take0 |=> !O_STROBE[0] && O_STROBE[1]) else $error("bank0 drop");
	a_bank1_strobe_drop: assert property (take1 |=> !O_STROBE[1] && O_STROBE[0]) else $error("bank1 drop");
	a_strobe_release: assert property (!O_STROBE[0] && $fell(I_CMD_ACTIVE) |-> ##[1:2] O_STROBE[0])
		else $error("no release");
	a_drop_needs_take: assert property ($fell(O_STROBE[1]) |-> $past(hit)) else $error("stray drop");
	a_latch_follow: assert property (O_STROBE[1] |=> O_BANK1.addr == $past(I_ADDR)) else $error("follow");
	a_chip_enable: assert property (take0 |=> O_BANK0.ce == 8'h01 << $past(I_ADDR[19:17])) else $error("ce");
	a_wait_same_bank: assert property (same |=> O_WAIT ##1 O_WAIT ##1 !O_WAIT) else $error("wait");
	a_no_wait_other: assert property (hit && !(have_ff && I_ADDR[1] == last_ff) |=> !O_WAIT)
		else $error("spurious wait");
	a_strobe_release_b1: assert property (!O_STROBE[1] && $fell(I_CMD_ACTIVE) |-> ##[1:2] O_STROBE[1])
		else $error("no release bank1");
	a_chip_enable_b1: assert property (take1 |=> O_BANK1.ce == 8'h01 << $past(I_ADDR[19:17])) else $error("ce1");
	a_miss_no_enable: assert property (O_STROBE[0] && I_ADDR[23:20] != tbis_pkg::MEM_REGION |=> O_BANK0.ce == 8'h00)
		else $error("ce on miss");
endmodule
bind tbis_interleave_ctrl tbis_interleave_monitor u_mon (.I_CLK_SYS, .I_RST, .I_ADDR, .I_CMD_FIRST, .I_CMD_ACTIVE,
	.O_STROBE, .O_BANK0, .O_BANK1, .O_WAIT);

// *** bench/tbis_cpu_model.sv ***
// Processor bus model issuing one command per request
`timescale 1ns/100ps
module tbis_cpu_model
(
	input  wire logic        i_clk,    // Bus clock
	input  wire logic        i_rst,    // Reset
	input  wire logic        i_go,     // Start command
	input  wire logic [23:0] i_addr,   // Address
	input  wire logic [2:0]  i_len,    // Length, 1 or more
	input  wire logic        i_wait,   // Wait state
	output logic [23:0]      o_addr,   // Early address
	output logic             o_first,  // First command state
	output logic             o_active  // Command active
);
	logic [2:0] cnt_ff;
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_ff   <= 3'h0;
			o_first  <= 1'h0;
			o_active <= 1'h0;
			o_addr   <= 24'h0;
		end
		else
		begin
			o_first <= i_go;
			if (i_go)
			begin
				o_addr   <= i_addr;
				o_active <= 1'h1;
				cnt_ff   <= i_len;
			end
			else if (cnt_ff != 3'h0)
				cnt_ff <= cnt_ff - {2'h0, !i_wait};
			else if (o_active)
			begin
				o_active <= 1'h0;
				o_addr   <= ~o_addr;
			end
		end
	end
endmodule

// *** bench/tbis_interleave_ctrl_tb.sv ***
// Self-checking bench for the interleave strobe control
`timescale 1ns/100ps
module tbis_interleave_ctrl_tb;
	logic                     clk = 1'h0;
	logic                     rst = 1'h1;
	logic                     go = 1'h0;
	logic [23:0]              addr = 24'h0;
	logic [2:0]               len = 3'h1;
	logic [23:0]              bus_addr;
	logic                     first;
	logic                     active;
	logic                     stall;
	logic [1:0]               strobe;
	logic [1:0]               prev;
	tbis_pkg::tbis_bank_bus_t bank0;
	tbis_pkg::tbis_bank_bus_t bank1;
	logic                     have = 1'h0;
	logic                     last;
	logic [34:0]              notes[$];
	logic [23:0]              pick;
	logic                     timed_out = 1'h0;
	int                       num_errors = 0;
	int                       comparisons = 0;
	always #4 clk = ~clk;
	tbis_cpu_model u_cpu (.i_clk(clk), .i_rst(rst), .i_go(go), .i_addr(addr), .i_len(len), .i_wait(stall),
		.o_addr(bus_addr), .o_first(first), .o_active(active));
	tbis_interleave_ctrl u_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_ADDR(bus_addr), .I_CMD_FIRST(first),
		.I_CMD_ACTIVE(active), .O_STROBE(strobe), .O_BANK0(bank0), .O_BANK1(bank1), .O_WAIT(stall));
	task automatic check(input logic [34:0] seen, input logic [34:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD addr_strobe_wait expected %h seen %h", exp, seen);
		end
	endtask
	task automatic conclude();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic access(input logic [23:0] a);
		int n;
		n = 0;
		go   <= 1'h1;
		addr <= a;
		len  <= 3'($urandom_range(7, 1));
		@(posedge clk);
		go <= 1'h0;
		if (a[23:20] == 4'h0)
		begin
			notes.push_back({a, 8'h01 << a[19:17], a[1] ? 2'h1 : 2'h2, have && a[1] == last});
			have = 1'h1;
			last = a[1];
		end
		repeat (2) @(posedge clk);
		while (active !== 1'h0 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 40)
		begin
			num_errors++;
			timed_out = 1'h1;
		end
		repeat (2) @(posedge clk);
	endtask
	always @(posedge clk)
	begin
		if (prev == 2'h3 && strobe !== 2'h3 && !rst)
			check({strobe[0] ? bank1 : bank0, strobe, stall}, notes.pop_front());
		prev <= strobe;
	end
	initial
	begin
		void'($urandom(18359));
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 70; i++)
		begin
			if (timed_out)
				break;
			pick = 24'($urandom);
			if (i % 7 != 0)
				pick[23:20] = 4'h0;
			if (i == 60)
			begin
				rst <= 1'h1;
				repeat (2) @(posedge clk);
				rst <= 1'h0;
				have = 1'h0;
			end
			access(pick);
		end
		check(35'(notes.size()), 35'h0);
		conclude();
	end
endmodule
